// file: rtl/crf_pkg.sv
// Constants and types shared by the capture routing channel
package crf_pkg;

  localparam int WORD_W = 24;
  localparam int TOUT_W = 16;
  localparam int NTF_W  = 5;
  localparam int FLG_W  = 3;

  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_TOUT   = 8'h04;
  localparam logic [7:0] ADDR_NOTIFY = 8'h08;
  localparam logic [7:0] ADDR_MASK   = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_EDGE_COUNTER_VALUE   = 8'h14;

  localparam int CTRL_ROUTE_EN = 0;
  localparam int CTRL_CHAN_EN  = 1;
  localparam int CTRL_EDGE_LSB = 2;
  localparam int CTRL_W0_LSB   = 4;
  localparam int CTRL_W1_LSB   = 6;
  localparam int CTRL_W        = 8;

  localparam int NTF_CAPT = 0;
  localparam int NTF_DONE = 1;
  localparam int NTF_OVF  = 3;
  localparam int NTF_TOUT = 4;

  localparam int FLG_LEVEL = 0;
  localparam int FLG_OVF   = 1;
  localparam int FLG_TOUT  = 2;

  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h0c;
  localparam logic [TOUT_W-1:0] TOUT_RST = 16'h0000;
  localparam logic [NTF_W-1:0]  MASK_RST = 5'h00;

  typedef enum logic [1:0] {
    CRF_SRC_TSTAMP  = 2'h0,
    CRF_SRC_EDGE_COUNTER_VALUE    = 2'h1,
    CRF_SRC_LVL_CNT = 2'h2,
    CRF_SRC_ZERO    = 2'h3
  } crf_src_t;

  typedef enum logic [1:0] {
    CRF_IDLE = 2'b01,
    CRF_BUSY = 2'b10
  } crf_state_t;

endpackage

// file: rtl/crf_sync2.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module crf_sync2 #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  always_comb begin
    meta_nxt = ce ? d : meta_r;
    q_nxt    = ce ? meta_r : q_r;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q_r    <= '0;
    end else begin
      meta_r <= meta_nxt;
      q_r    <= q_nxt;
    end
  end

  assign q = q_r;
endmodule
`default_nettype wire

// file: rtl/crf_tdu.sv
// Timeout unit: pulses when no edge is seen for a programmed span
`timescale 1ns/1ps
`default_nettype none
module crf_tdu #(
  parameter int TW = 16
) (
  input  wire logic          mclk,
  input  wire logic          rst_n,
  input  wire logic          ce,
  input  wire logic [TW-1:0] limit,
  input  wire logic          restart,
  output logic               tout
);
  logic [TW-1:0] cnt_r;
  logic [TW-1:0] cnt_nxt;
  logic          tout_r;
  logic          tout_nxt;
  logic [TW-1:0] cnt_inc;

  always_comb begin
    cnt_inc  = TW'(cnt_r + 1'b1);
    cnt_nxt  = cnt_r;
    tout_nxt = 1'b0;
    if (ce) begin
      if (restart || limit == '0) begin
        cnt_nxt = '0;
      end else if (cnt_inc == limit) begin
        // Rearms so a dead input keeps reporting
        cnt_nxt  = '0;
        tout_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_inc;
      end
    end else begin
      tout_nxt = tout_r;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r  <= '0;
      tout_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tout_r <= tout_nxt;
    end
  end

  assign tout = tout_r & ce;
endmodule
`default_nettype wire

// file: rtl/crf_top.sv
// Timer input channel feeding captures and flags to the routing unit
`timescale 1ns/1ps
`default_nettype none
module crf_top #(
  parameter int WW = crf_pkg::WORD_W,
  parameter int TW = crf_pkg::TOUT_W
) (
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  input  wire logic                   ce,
  input  wire logic [7:0]             paddr,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   sig_in,
  input  wire logic                   route_slot,
  input  wire logic                   route_ack,
  output logic                        route_req,
  output logic      [WW-1:0]          route_w0,
  output logic      [WW-1:0]          route_w1,
  output logic      [crf_pkg::FLG_W-1:0] route_flags,
  output logic                        irq
);
  import crf_pkg::*;

  localparam int SLOT_W = 2 * WW + FLG_W;

  function automatic logic [WW-1:0] word_pick(
    input logic [1:0]    sel,
    input logic [WW-1:0] ts,
    input logic [WW-1:0] ec,
    input logic          lvl
  );
    logic [WW-1:0] w;
    w = '0;
    case (crf_src_t'(sel))
      CRF_SRC_TSTAMP:  w = ts;
      CRF_SRC_EDGE_COUNTER_VALUE:    w = ec;
      CRF_SRC_LVL_CNT: w = {lvl, ec[WW-2:0]};
      default:         w = '0;
    endcase
    return w;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  logic              lvl_s;
  logic              lvl_q_r;
  logic              tout_ev;
  logic [CTRL_W-1:0] ctrl_r;
  logic [CTRL_W-1:0] ctrl_nxt;
  logic [TW-1:0]     tlim_r;
  logic [TW-1:0]     tlim_nxt;
  logic [NTF_W-1:0]  ntf_r;
  logic [NTF_W-1:0]  ntf_nxt;
  logic [NTF_W-1:0]  mask_r;
  logic [NTF_W-1:0]  mask_nxt;
  logic [31:0]       prdata_r;
  logic [31:0]       prdata_nxt;
  logic              miss_r;
  logic              miss_nxt;
  logic [WW-1:0]     ts_r;
  logic [WW-1:0]     ts_nxt;
  logic [WW-1:0]     edge_counter_value_r;
  logic [WW-1:0]     edge_counter_value_nxt;
  crf_state_t        st_r;
  crf_state_t        st_nxt;
  logic [SLOT_W-1:0] act_r;
  logic [SLOT_W-1:0] act_nxt;
  logic [SLOT_W-1:0] shd_r;
  logic [SLOT_W-1:0] shd_nxt;
  logic              shd_v_r;
  logic              shd_v_nxt;
  logic              capture;
  logic              req_ev;
  logic              busy;
  logic              ev_busy;
  logic              acked;
  logic              s_v;
  logic [SLOT_W-1:0] s_slot;
  logic [SLOT_W-1:0] new_slot;
  logic              setup;
  logic              wr_acc;
  logic [NTF_W-1:0]  ntf_set;
  logic [NTF_W-1:0]  ntf_clr;

  crf_sync2 #(.W(1)) u_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .ce    (ce),
    .d     (sig_in),
    .q     (lvl_s)
  );

  crf_tdu #(.TW(TW)) u_tdu (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .ce      (ce),
    .limit   (tlim_r),
    .restart (lvl_s ^ lvl_q_r),
    .tout    (tout_ev)
  );

  //////////////////////////////////////////////////////////////////////////
  // Capture and routing request
  assign capture = ctrl_r[CTRL_CHAN_EN] & ce &
                   ((lvl_s & ~lvl_q_r & ctrl_r[CTRL_EDGE_LSB]) |
                    (~lvl_s & lvl_q_r & ctrl_r[CTRL_EDGE_LSB+1]));
  assign busy    = (st_r == CRF_BUSY);
  assign req_ev  = ctrl_r[CTRL_ROUTE_EN] &
                   (capture | (tout_ev & ctrl_r[CTRL_CHAN_EN]));
  assign ev_busy = busy & req_ev;
  // ack only counts in a routing slot
  assign acked   = busy & route_ack & route_slot & ce;

  always_comb begin
    edge_counter_value_nxt = capture ? WW'(edge_counter_value_r + 1'b1) : edge_counter_value_r;
    ts_nxt   = ce ? WW'(ts_r + 1'b1) : ts_r;
    // level and words in one slot
    new_slot = {word_pick(ctrl_r[CTRL_W0_LSB+:2], ts_r, edge_counter_value_nxt, lvl_s),
                word_pick(ctrl_r[CTRL_W1_LSB+:2], ts_r, edge_counter_value_nxt, lvl_s),
                tout_ev, ev_busy, lvl_s};
    // late event lands in shadow, taken at ack
    s_v      = shd_v_r | ev_busy;
    s_slot   = ev_busy ? new_slot : shd_r;
    st_nxt    = st_r;
    act_nxt   = act_r;
    shd_nxt   = shd_r;
    shd_v_nxt = shd_v_r;
    case (st_r)
      CRF_IDLE: begin
        if (req_ev) begin
          act_nxt = new_slot;
          st_nxt  = CRF_BUSY;
        end
      end
      CRF_BUSY: begin
        if (acked) begin
          shd_v_nxt = 1'b0;
          if (s_v) begin
            act_nxt = s_slot;
          end else begin
            st_nxt = CRF_IDLE;
          end
        end else if (ce) begin
          // later event overwrites shadow, overflow set
          shd_v_nxt = s_v;
          shd_nxt   = s_slot;
        end
      end
      default: begin
        st_nxt    = CRF_IDLE;
        shd_v_nxt = 1'b0;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Register bus
  assign setup   = psel & ~penable & ce;
  assign wr_acc  = psel & penable & pwrite & ce & ~miss_r;
  assign ntf_set = {tout_ev & ctrl_r[CTRL_CHAN_EN], ev_busy, 1'b0,
                    acked, capture};
  assign ntf_clr = (wr_acc && paddr == ADDR_NOTIFY) ?
                   pwdata[NTF_W-1:0] : '0;

  always_comb begin
    ctrl_nxt   = ctrl_r;
    tlim_nxt   = tlim_r;
    mask_nxt   = mask_r;
    // Set beats a simultaneous clear
    ntf_nxt    = (ntf_r & ~ntf_clr) | ntf_set;
    prdata_nxt = prdata_r;
    miss_nxt   = miss_r;
    if (wr_acc) begin
      case (paddr)
        ADDR_CTRL: ctrl_nxt = pwdata[CTRL_W-1:0];
        ADDR_TOUT: tlim_nxt = pwdata[TW-1:0];
        ADDR_MASK: mask_nxt = pwdata[NTF_W-1:0];
        default:   ;
      endcase
    end
    // Read data fixed in setup so it is a flop at access
    if (setup) begin
      miss_nxt   = 1'b0;
      prdata_nxt = '0;
      case (paddr)
        ADDR_CTRL:   prdata_nxt = 32'(ctrl_r);
        ADDR_TOUT:   prdata_nxt = 32'(tlim_r);
        ADDR_NOTIFY: prdata_nxt = 32'(ntf_r);
        ADDR_MASK:   prdata_nxt = 32'(mask_r);
        ADDR_STATUS: prdata_nxt = 32'({shd_v_r, busy, lvl_s});
        ADDR_EDGE_COUNTER_VALUE:   prdata_nxt = 32'(edge_counter_value_r);
        default:     miss_nxt   = 1'b1;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r   <= CTRL_RST;
      tlim_r   <= TOUT_RST;
      mask_r   <= MASK_RST;
      ntf_r    <= '0;
      prdata_r <= '0;
      miss_r   <= 1'b0;
      lvl_q_r  <= 1'b0;
      ts_r     <= '0;
      edge_counter_value_r   <= '0;
      st_r     <= CRF_IDLE;
      act_r    <= '0;
      shd_r    <= '0;
      shd_v_r  <= 1'b0;
    end else begin
      ctrl_r   <= ctrl_nxt;
      tlim_r   <= tlim_nxt;
      mask_r   <= mask_nxt;
      ntf_r    <= ntf_nxt;
      prdata_r <= prdata_nxt;
      miss_r   <= miss_nxt;
      lvl_q_r  <= ce ? lvl_s : lvl_q_r;
      ts_r     <= ts_nxt;
      edge_counter_value_r   <= edge_counter_value_nxt;
      st_r     <= st_nxt;
      act_r    <= act_nxt;
      shd_r    <= shd_nxt;
      shd_v_r  <= shd_v_nxt;
    end
  end

  assign prdata      = prdata_r;
  assign pready      = ce;
  assign pslverr     = psel & penable & miss_r;
  assign route_req   = busy;
  assign route_w0    = act_r[SLOT_W-1 -: WW];
  assign route_w1    = act_r[FLG_W +: WW];
  assign route_flags = act_r[FLG_W-1:0];
  assign irq         = |(ntf_r & mask_r);

  //////////////////////////////////////////////////////////////////////////
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  req_raise_a: assert property (
    ce && !busy && req_ev |=> route_req)
    else $error("request not raised after event");

  ovf_flag_a: assert property (
    ce && busy && !acked && req_ev |=> shd_v_r && shd_r[FLG_OVF])
    else $error("overflow flag not set on second event");

  tout_flag_a: assert property (
    ce && !busy && tout_ev && req_ev |=> route_flags[FLG_TOUT])
    else $error("timeout flag missing");

  level_flag_a: assert property (
    ce && !busy && req_ev |=> route_flags[FLG_LEVEL] == $past(lvl_s)
      && !route_flags[FLG_OVF])
    else $error("level flag does not match capture");

  late_level_a: assert property (
    (ce && busy && !acked && req_ev) ##1 (acked && !req_ev)
      |=> route_req && route_flags[FLG_OVF]
      && route_flags[FLG_LEVEL] == $past(lvl_s, 2))
    else $error("late capture level lost");

  slot_gate_a: assert property (
    busy && route_ack && !route_slot |=> route_req && $stable(act_r))
    else $error("ack taken outside routing slot");

  level_word_a: assert property (
    ce && !busy && req_ev
      && ctrl_r[CTRL_W0_LSB+:2] == CRF_SRC_LVL_CNT
      |=> route_w0[WW-1] == route_flags[FLG_LEVEL])
    else $error("level in word disagrees with flag");

  notify_ovf_a: assert property (
    ev_busy |=> ntf_r[NTF_OVF])
    else $error("overflow notify bit not set");

  req_hold_a: assert property (
    busy && !acked |=> route_req && $stable(route_w0)
      && $stable(route_w1) && $stable(route_flags))
    else $error("request changed before ack");

  cov_single: cover property (!busy && req_ev ##[1:20] acked);
  cov_late:   cover property (ev_busy ##1 acked);
  cov_tout:   cover property (tout_ev && req_ev);
endmodule
`default_nettype wire

// file: testbench/crf_route_model.sv
// Behavioural routing unit that serves the channel's requests
`timescale 1ns/1ps
`default_nettype none
module crf_route_model #(
  parameter int RTT = 2
) (
  input  wire logic        mclk,
  input  wire logic        half,
  input  wire logic [7:0]  lag,
  input  wire logic        route_req,
  input  wire logic [23:0] route_w0,
  input  wire logic [23:0] route_w1,
  input  wire logic [2:0]  route_flags,
  output logic             route_slot,
  output logic             route_ack,
  output logic             got,
  output logic [50:0]      got_word
);
  logic [7:0] cnt;

  initial begin
    route_slot = 1'b1;
    route_ack  = 1'b0;
    got        = 1'b0;
    got_word   = '0;
    cnt        = 8'h00;
  end

  always @(posedge mclk) begin
    route_slot <= half ? ~route_slot : 1'b1;
    got        <= 1'b0;
    // words taken at ack in a slot
    if (route_ack && route_slot) begin
      route_ack <= 1'b0;
      cnt       <= 8'h00;
      got       <= 1'b1;
      got_word  <= {route_flags, route_w1, route_w0};
    end else if (route_req && !route_ack) begin
      cnt <= cnt + 8'h01;
      // served after round trip; may rise off-slot and wait
      if (cnt + 8'h01 >= lag && cnt >= RTT)
        route_ack <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: testbench/testbench.sv
// Self-checking bench for the capture routing channel
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import crf_pkg::*;
  logic        mclk, rst_n, ce, psel, penable, pwrite, sig_in, half, lvl;
  logic        pready, pslverr, route_slot, route_ack, route_req, irq;
  logic        got, er;
  logic [7:0]  paddr, lag, ctl;
  logic [31:0] pwdata, prdata, rd;
  logic [23:0] route_w0, route_w1, n;
  logic [2:0]  route_flags;
  logic [50:0] got_word, ex;
  logic [50:0] exp_q[$];
  int          error_cnt, tests_run, seed, d, h, i;

  crf_top #(.WW(24), .TW(16)) i_crf_top (.mclk(mclk), .rst_n(rst_n),
    .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sig_in(sig_in), .route_slot(route_slot),
    .route_ack(route_ack), .route_req(route_req), .route_w0(route_w0),
    .route_w1(route_w1), .route_flags(route_flags), .irq(irq));
  crf_route_model i_crf_route_model (.mclk(mclk), .half(half), .lag(lag),
    .route_req(route_req), .route_w0(route_w0), .route_w1(route_w1),
    .route_flags(route_flags), .route_slot(route_slot),
    .route_ack(route_ack), .got(got), .got_word(got_word));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [47:0] e, g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic end_sim;
    $display("Checks run %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Idle cycle first, so psel is never assigned twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int k;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    // Answer and read data are taken at the sampling edge itself
    @(posedge mclk);
    while (pready !== 1'b1) begin
      k++;
      if (k > 40) begin
        chk("pready", 48'h1, 48'h0);
        end_sim();
      end
      @(posedge mclk);
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(nm, {16'h0, e}, {16'h0, rd & m});
    chk("pslverr", 48'h0, {47'h0, er});
  endtask

  task automatic irq_chk(input logic v);
    @(negedge mclk);
    chk("irq", {47'h0, v}, {47'h0, irq});
  endtask

  function automatic logic [23:0] wsrc(input logic [1:0] s);
    case (s)
      2'h1: return n;
      2'h2: return {lvl, n[22:0]};
      default: return 24'h0;
    endcase
  endfunction

  task automatic edge_ev(input logic ovf, input logic tout);
    n = n + 24'h1;
    lvl = ~lvl;
    sig_in <= lvl;
    exp_q.push_back({tout, ovf, lvl, wsrc(ctl[7:6]), wsrc(ctl[5:4])});
  endtask

  task automatic drain;
    int k;
    k = 0;
    while (exp_q.size() != 0) begin
      @(posedge mclk);
      k++;
      if (k > 400) begin
        chk("transfer count", 48'h0, 48'h1);
        end_sim();
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    if (got === 1'b1) begin
      if (exp_q.size() == 0) chk("extra transfer", 48'h0, 48'h1);
      else begin
        ex = exp_q.pop_front();
        chk("words", ex[47:0], got_word[47:0]);
        chk("level", {47'h0, ex[48]}, {47'h0, got_word[48]});
        chk("ovf tout", {46'h0, ex[50:49]}, {46'h0, got_word[50:49]});
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'ha3f7;
    {rst_n, psel, penable, pwrite, sig_in, half, lvl} = 7'h0;
    ce = 1'b1;
    paddr = 8'h0;
    pwdata = 32'h0;
    lag = 8'h4;
    n = 24'h0;
    ctl = 8'h0;
    error_cnt = 0;
    tests_run = 0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    rdchk("ctrl reset", ADDR_CTRL, 32'h0000000c, 32'hffffffff);
    rdchk("mask reset", ADDR_MASK, 32'h0, 32'hffffffff);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped slverr", 48'h1, {47'h0, er});
    chk("unmapped rdata", 48'h0, {16'h0, rd});
    $display("Test registers done");
    for (i = 0; i < 3; i++) begin
      ctl = (i == 0) ? 8'h9f : (i == 1) ? 8'h6f : 8'h7f;
      wr(ADDR_CTRL, {24'h0, ctl});
      for (d = 0; d < 3; d++) begin
        lag <= 8'(2 + {$random(seed)} % 8);
        edge_ev(1'b0, 1'b0);
        repeat (20 + {$random(seed)} % 16) @(posedge mclk);
      end
      drain();
      rdchk("edge count", ADDR_EDGE_COUNTER_VALUE, {8'h0, n}, 32'h00ffffff);
    end
    $display("Test word sources done");
    // Second edge lands while pending, last case one cycle before ack
    lag <= 8'h6;
    for (h = 0; h < 2; h++) begin
      half <= h[0];
      for (d = 2; d <= 6; d++) begin
        edge_ev(1'b0, 1'b0);
        repeat (d) @(posedge mclk);
        edge_ev(1'b1, 1'b0);
        drain();
        repeat (8) @(posedge mclk);
      end
    end
    rdchk("ovf notify", ADDR_NOTIFY, 32'h08, 32'h18);
    $display("Test overflow done");
    wr(ADDR_NOTIFY, 32'h1f);
    // Timeout alone raises a request; limit cut before the next one
    exp_q.push_back({2'b10, lvl, wsrc(ctl[7:6]), wsrc(ctl[5:4])});
    wr(ADDR_TOUT, 32'h20);
    drain();
    wr(ADDR_TOUT, 32'h0);
    rdchk("tout notify", ADDR_NOTIFY, 32'h10, 32'h18);
    wr(ADDR_MASK, 32'h10);
    irq_chk(1'b1);
    wr(ADDR_NOTIFY, 32'h10);
    irq_chk(1'b0);
    // Transfer done bit left set by the timeout transfer
    wr(ADDR_MASK, 32'h02);
    irq_chk(1'b1);
    wr(ADDR_NOTIFY, 32'h1f);
    irq_chk(1'b0);
    $display("Test timeout and irq done");
    end_sim();
  end
endmodule
`default_nettype wire
